// file: common/mds_pkg.sv
// Purpose: Shared constants for the motor driver status bank
// Assumes: 16-bit serial frames, 8-bit status registers
// Notes:   Offsets are 6-bit register indices within the serial frame
package mds_pkg;
  // Register offsets
  localparam logic [5:0] OFS_SUMMARY    = 6'h00;
  localparam logic [5:0] OFS_THERMAL_OC = 6'h01;
  localparam logic [5:0] OFS_SUPPLY     = 6'h02;
  localparam logic [5:0] OFS_LAST_VALID = 6'h0C;
  // Reset values
  localparam logic [7:0] STAT_RST       = 8'h00;
  // Summary register fields
  localparam int SUM_STALL  = 7;
  localparam int SUM_REGF   = 6;
  localparam int SUM_SERF   = 5;
  localparam int SUM_OC     = 4;
  localparam int SUM_SUPPLY_POR_CLEAR_FLAG   = 3;
  localparam int SUM_OVP    = 2;
  localparam int SUM_THERM  = 1;
  localparam int SUM_FAULT  = 0;
  // Thermal and overcurrent register fields
  localparam int TOC_WARN   = 7;
  localparam int TOC_SHUT   = 6;
  // Frame layout
  localparam int FRM_RW     = 15;
  localparam int FRM_ADR_HI = 14;
  localparam int FRM_ADR_LO = 9;
  localparam logic [4:0] FRM_BITS     = 5'h10;
  localparam logic [4:0] FRM_ADR_DONE = 5'h07;
  localparam logic [4:0] FRM_CNT_MAX  = 5'h11;
  // Sticky event indices
  localparam int EV_FRAME   = 0;
  localparam int EV_PARITY  = 1;
  localparam int EV_ADDR    = 2;
  localparam int EV_WARN    = 3;
  localparam int EV_SHUT    = 4;
  localparam int EV_POR     = 5;
  localparam int EV_NUM     = 6;
  localparam logic [EV_NUM-1:0] EV_RST = 6'h20;
endpackage

// file: hw/mds_sticky.sv
// Purpose: One latched event bit with set priority
// Assumes: Set, clear and init are synchronous to mclk
// Notes:   Init returns the bit to its power-up value
`timescale 1ns/100ps
module mds_sticky #(
  parameter logic RST_VAL = 1'b0
) (
  input  logic mclk,   // System clock
  input  logic rst,    // Async reset, active high
  input  logic init,   // Return to power-up value
  input  logic set,    // Event seen
  input  logic clr,    // Fault clear
  output logic flag    // Latched state
);
  logic flag_ff;
  logic nxt_flag;

  // Set wins over clear
  assign nxt_flag = init ? RST_VAL : (set ? 1'b1 : (clr ? 1'b0 : flag_ff));

  // State flop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flag_ff <= RST_VAL;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag = flag_ff;
endmodule // mds_sticky

// file: hw/mds_status_bank.sv
// Purpose: Read-only status bank of a three-phase motor driver, read by 16-bit serial frames
// Assumes: Serial pins and condition inputs are synchronous to mclk; sclk well below mclk/2
// Notes:   Rules carried by this block are listed below
`timescale 1ns/100ps
module mds_status_bank
  import mds_pkg::*;
(
  input  logic       mclk,                  // System clock, 10 MHz
  input  logic       rst,                   // Async reset, active high
  input  logic       sleep_pin_n,           // Low holds the device in sleep
  input  logic       fault_clear_bit,       // Fault clear command pulse
  input  logic       motor_stall_det,       // Stall condition level
  input  logic       regulator_fault_det,   // Regulator fault level
  input  logic       supply_por_det,        // Motor supply power-on reset event
  input  logic       supply_ovp_det,        // Motor supply overvoltage level
  input  logic       thermal_warning_det,   // Die temperature above warning trip
  input  logic       thermal_shutdown_det,  // Die temperature above shutdown trip
  input  logic [5:0] switch_oc_det,         // Overcurrent per switch, C high..A low
  input  logic [7:0] supply_link_in,        // Contents of the third status register
  input  logic       sclk,                  // Serial clock
  input  logic       scs_n,                 // Serial select, active low
  input  logic       sdi,                   // Serial data in
  output logic       sdo,                   // Serial data out
  output logic       sdo_oe,                // Drive enable for sdo
  output logic [7:0] summary_fault_status   // Summary register copy
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]        sum_ff, nxt_sum;
  logic [7:0]        toc_ff, nxt_toc;
  logic [7:0]        sup_ff;
  logic              sclk_q_ff, scs_q_ff;
  logic [4:0]        cnt_ff;
  logic [15:0]       rx_ff, tx_ff;
  logic              sdo_ff, sdo_oe_ff;
  logic [EV_NUM-1:0] ev_set, ev_flag;
  logic              sclk_fall, sclk_rise, cs_fall, cs_rise, asleep;
  logic              full_frame, frame_err, parity_err, addr_err;
  logic [5:0]        rd_adr;
  logic [7:0]        rd_data;
  logic              serial_fault_flag, overcurrent_flag, thermal_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Latched events
  assign asleep = ~sleep_pin_n;
  assign ev_set[EV_FRAME]  = frame_err;
  assign ev_set[EV_PARITY] = parity_err;
  assign ev_set[EV_ADDR]   = addr_err;
  assign ev_set[EV_WARN]   = thermal_warning_det;
  assign ev_set[EV_SHUT]   = thermal_shutdown_det;
  assign ev_set[EV_POR]    = supply_por_det;

  // One sticky cell per event, defaults restored in sleep
  generate
    for (genvar gi = 0; gi < EV_NUM; gi++) begin : g_ev
      mds_sticky #(.RST_VAL(EV_RST[gi])) u_ev (
        .mclk (mclk),
        .rst  (rst),
        .init (asleep),
        .set  (ev_set[gi]),
        .clr  (fault_clear_bit),
        .flag (ev_flag[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register contents
  assign serial_fault_flag = ev_flag[EV_FRAME] | ev_flag[EV_PARITY] | ev_flag[EV_ADDR];
  assign overcurrent_flag  = |switch_oc_det;
  assign thermal_flag      = ev_flag[EV_WARN] | ev_flag[EV_SHUT];

  // Summary register next value
  always_comb begin
    nxt_sum            = STAT_RST;
    nxt_sum[SUM_STALL] = motor_stall_det;
    nxt_sum[SUM_REGF]  = regulator_fault_det;
    nxt_sum[SUM_SERF]  = serial_fault_flag;
    nxt_sum[SUM_OC]    = overcurrent_flag;
    nxt_sum[SUM_SUPPLY_POR_CLEAR_FLAG]  = ~ev_flag[EV_POR];
    nxt_sum[SUM_OVP]   = supply_ovp_det;
    nxt_sum[SUM_THERM] = thermal_flag;
    nxt_sum[SUM_FAULT] = motor_stall_det | regulator_fault_det | serial_fault_flag
                       | overcurrent_flag | supply_ovp_det | thermal_flag;
  end

  // Thermal and overcurrent register next value
  always_comb begin
    nxt_toc           = STAT_RST;
    nxt_toc[TOC_WARN] = ev_flag[EV_WARN];
    nxt_toc[TOC_SHUT] = ev_flag[EV_SHUT];
    nxt_toc[5:0]      = switch_oc_det;
  end

  // Status flops, cleared in reset and sleep
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sum_ff <= STAT_RST;
      toc_ff <= STAT_RST;
      sup_ff <= STAT_RST;
    end else if (asleep) begin
      sum_ff <= STAT_RST;
      toc_ff <= STAT_RST;
      sup_ff <= STAT_RST;
    end else begin
      sum_ff <= nxt_sum;
      toc_ff <= nxt_toc;
      sup_ff <= supply_link_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame decode
  assign sclk_fall  = sclk_q_ff & ~sclk & ~scs_n;
  assign sclk_rise  = ~sclk_q_ff & sclk & ~scs_n;
  assign cs_fall    = scs_q_ff & ~scs_n;
  assign cs_rise    = ~scs_q_ff & scs_n;
  assign full_frame = (cnt_ff == FRM_BITS);
  assign frame_err  = cs_rise & ~full_frame & sleep_pin_n;
  assign parity_err = cs_rise & full_frame & (^rx_ff) & sleep_pin_n;
  assign addr_err   = cs_rise & full_frame & sleep_pin_n
                    & (rx_ff[FRM_ADR_HI:FRM_ADR_LO] > OFS_LAST_VALID);
  assign rd_adr     = rx_ff[5:0];  // Address once seven bits are in

  // Read mux, other offsets answer zero
  assign rd_data = (rd_adr == OFS_SUMMARY)    ? sum_ff :
                   (rd_adr == OFS_THERMAL_OC) ? toc_ff :
                   (rd_adr == OFS_SUPPLY)     ? sup_ff :
                   STAT_RST;

  // Pin history for edge detection
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_q_ff <= 1'b0;
      scs_q_ff  <= 1'b1;
    end else begin
      sclk_q_ff <= sclk;
      scs_q_ff  <= scs_n;
    end
  end

  // Receive shifter and bit counter; writes are never applied
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_ff  <= 16'h0000;
      cnt_ff <= 5'h00;
    end else if (asleep || cs_fall) begin
      rx_ff  <= 16'h0000;
      cnt_ff <= 5'h00;
    end else if (sclk_fall) begin
      rx_ff  <= {rx_ff[14:0], sdi};
      cnt_ff <= (cnt_ff == FRM_CNT_MAX) ? cnt_ff : cnt_ff + 5'h01;
    end
  end

  // Reply word: status byte then register byte, shifted on rising sclk
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_ff     <= 16'h0000;
      sdo_ff    <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end else if (asleep) begin
      tx_ff     <= 16'h0000;
      sdo_ff    <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end else begin
      sdo_oe_ff <= ~scs_n;
      if (cs_fall) begin
        tx_ff[15:8] <= sum_ff;
        sdo_ff      <= sum_ff[7];
      end else if (cnt_ff == FRM_ADR_DONE) begin
        tx_ff[7:0]  <= rd_data;
      end
      if (sclk_rise && cnt_ff != 5'h00 && cnt_ff < FRM_BITS) begin
        sdo_ff <= tx_ff[~cnt_ff[3:0]];
      end
    end
  end

  assign sdo                  = sdo_ff;
  assign sdo_oe               = sdo_oe_ff;
  assign summary_fault_status = sum_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_reset_zero;
    @(posedge mclk) $fell(rst) |-> (sum_ff == STAT_RST && toc_ff == STAT_RST);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("status not zero after reset");

  property p_stall;
    @(posedge mclk) disable iff (rst)
      (sleep_pin_n && motor_stall_det) |=> sum_ff[SUM_STALL];
  endproperty
  a_stall: assert property (p_stall) else $error("stall flag missing");

  property p_oc_summary;
    @(posedge mclk) disable iff (rst)
      (sleep_pin_n && switch_oc_det != 6'h00) |=> sum_ff[SUM_OC] && sum_ff[SUM_FAULT];
  endproperty
  a_oc_summary: assert property (p_oc_summary) else $error("overcurrent summary missing");

  property p_por_low;
    @(posedge mclk) disable iff (rst)
      (sleep_pin_n && supply_por_det) ##1 sleep_pin_n |=> !sum_ff[SUM_SUPPLY_POR_CLEAR_FLAG];
  endproperty
  a_por_low: assert property (p_por_low) else $error("power-on flag not low");

  property p_ovp;
    @(posedge mclk) disable iff (rst)
      sleep_pin_n |=> (sum_ff[SUM_OVP] == $past(supply_ovp_det));
  endproperty
  a_ovp: assert property (p_ovp) else $error("overvoltage flag wrong");

  property p_thermal_or;
    @(posedge mclk) disable iff (rst)
      (toc_ff[TOC_WARN] || toc_ff[TOC_SHUT]) && sleep_pin_n && $past(sleep_pin_n)
      && !$past(fault_clear_bit) |=> sum_ff[SUM_THERM];
  endproperty
  a_thermal_or: assert property (p_thermal_or) else $error("thermal summary missing");

  property p_switch_oc;
    @(posedge mclk) disable iff (rst)
      sleep_pin_n |=> (toc_ff[5:0] == $past(switch_oc_det));
  endproperty
  a_switch_oc: assert property (p_switch_oc) else $error("switch overcurrent wrong");

  property p_shut_hold;
    @(posedge mclk) disable iff (rst)
      (toc_ff[TOC_SHUT] && sleep_pin_n && !fault_clear_bit && !$past(fault_clear_bit))
      ##1 sleep_pin_n |=> toc_ff[TOC_SHUT];
  endproperty
  a_shut_hold: assert property (p_shut_hold) else $error("shutdown flag dropped");

  property p_sleep_clear;
    @(posedge mclk) disable iff (rst)
      !sleep_pin_n |=> (sum_ff == STAT_RST && toc_ff == STAT_RST && !sdo_oe);
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) else $error("sleep did not clear");

  property p_status_first;
    @(posedge mclk) disable iff (rst)
      (cs_fall && sleep_pin_n) |=> (sdo == $past(sum_ff[7]));
  endproperty
  a_status_first: assert property (p_status_first) else $error("status msb not first");
endmodule // mds_status_bank

// file: testbench/mds_spi_ctrl.sv
// Purpose: Serial controller model that reads the status bank
// Assumes: Pins change on falling mclk, each sclk phase is 3 mclk
// Notes:   Reply bits are taken as z whenever sdo is not driven
`timescale 1ns/100ps
module mds_spi_ctrl (
  input  logic mclk,    // System clock
  input  logic sdo,     // Reply data
  input  logic sdo_oe,  // Reply drive enable
  output logic sclk,    // Serial clock
  output logic scs_n,   // Select, active low
  output logic sdi      // Command data
);
  // Idle pins, sclk low at every select edge
  initial begin
    sclk = 1'b0;
    scs_n = 1'b1;
    sdi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // One frame of nb clocks, MSB first, idle gap after it
  task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge mclk) scs_n = 1'b0;
    repeat (3) @(negedge mclk);
    for (int i = 0; i < nb; i++) begin
      sclk = 1'b1;
      sdi = w[15-i];
      repeat (3) @(negedge mclk);
      rx = {rx[14:0], sdo_oe ? sdo : 1'bz};
      sclk = 1'b0;
      repeat (3) @(negedge mclk);
    end
    scs_n = 1'b1;
    sdi = ~sdi;
    repeat (6) @(negedge mclk);
  endtask
endmodule // mds_spi_ctrl

// file: testbench/mds_status_bank_tb_top.sv
// Purpose: Self-checking bench for the status bank
// Assumes: Inputs change on falling mclk
// Notes:   Flag model kept in bits, compared at every result
`timescale 1ns/100ps
module mds_status_bank_tb_top
  import mds_pkg::*;
;
  logic        mclk, rst, slp_n, fclr, stall, regf, por, supply_overvoltage_flag, tw, ts;
  logic [5:0]  oc;
  logic [7:0]  link, sum;
  logic        sclk, scs_n, sdi, sdo, sdo_oe;
  logic [15:0] rx;
  logic [31:0] r;
  int          n_mismatch = 0;
  int          compares = 0;
  bit          m_por, m_warn, m_shut, m_ser;

  ////////////////////////////////////////////////////////////////////
  // Design and serial partner
  mds_status_bank dut (
    .mclk(mclk), .rst(rst), .sleep_pin_n(slp_n), .fault_clear_bit(fclr),
    .motor_stall_det(stall), .regulator_fault_det(regf), .supply_por_det(por),
    .supply_ovp_det(supply_overvoltage_flag), .thermal_warning_det(tw), .thermal_shutdown_det(ts),
    .switch_oc_det(oc), .supply_link_in(link), .sclk(sclk), .scs_n(scs_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .summary_fault_status(sum)
  );
  mds_spi_ctrl u_ctrl (
    .mclk(mclk), .sdo(sdo), .sdo_oe(sdo_oe), .sclk(sclk), .scs_n(scs_n), .sdi(sdi)
  );

  // 100 ns clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////
  // Model of the summary register
  function automatic logic [7:0] e_sum();
    logic t;
    t = m_warn | m_shut;
    return {stall, regf, m_ser, |oc, ~m_por, supply_overvoltage_flag, t, stall | regf | m_ser | (|oc) | supply_overvoltage_flag | t};
  endfunction

  // Command word with even parity
  function automatic logic [15:0] mk(logic w, logic [5:0] a, logic [7:0] d);
    return {w, a, ^{w, a, d}, d};
  endfunction

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(negedge mclk);
  endtask

  // Apply conditions, thermal levels latch in the model
  task automatic drive(logic [31:0] v);
    {ts, tw, supply_overvoltage_flag, regf, stall} = v[4:0];
    oc = v[10:5];
    link = v[18:11];
    m_warn |= v[3];
    m_shut |= v[4];
    tick(3);
  endtask

  // Fault clear pulse, a live event wins
  task automatic clr();
    fclr = 1'b1;
    tick(1);
    fclr = 1'b0;
    m_warn = tw;
    m_shut = ts;
    m_ser = 1'b0;
    m_por = 1'b0;
    tick(3);
  endtask

  task automatic rd(logic [5:0] a, logic [7:0] d, string nm);
    logic [7:0] s;
    s = e_sum();
    u_ctrl.xfer(mk(1'b1, a, 8'h00), 16, rx);
    chk(nm, rx, {s, d});
    chk("drive released", {15'h0000, sdo_oe}, 16'h0000);
  endtask

  task automatic bad(logic [15:0] w, int nb);
    u_ctrl.xfer(w, nb, rx);
    m_ser = 1'b1;
    tick(2);
    chk("serial fault", {8'h00, sum}, {8'h00, e_sum()});
    clr();
  endtask

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, slp_n} = 2'b11;
    {fclr, stall, regf, por, supply_overvoltage_flag, tw, ts} = 7'h00;
    oc = 6'h00;
    link = 8'h00;
    {m_por, m_warn, m_shut, m_ser} = 4'b1000;
    r = $urandom(32'h25550781);
    tick(2);
    rst = 1'b0;
    tick(3);
    chk("summary reset", {8'h00, sum}, {8'h00, STAT_RST});
    rd(OFS_THERMAL_OC, STAT_RST, "reg1 reset");
    rd(OFS_SUPPLY, STAT_RST, "reg2 reset");
    clr();
    chk("por cleared", {8'h00, sum}, 16'h0008);
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      drive(r);
      if (r[20]) clr();
      chk("summary", {8'h00, sum}, {8'h00, e_sum()});
      rd(OFS_THERMAL_OC, {m_warn, m_shut, oc}, "reg1");
      rd(OFS_SUPPLY, link, "reg2");
      rd(OFS_SUMMARY, e_sum(), "reg0");
    end
    clr();
    drive(32'h18);
    drive(32'h00);
    rd(OFS_THERMAL_OC, 8'hC0, "thermal held");
    clr();
    rd(OFS_THERMAL_OC, 8'h00, "thermal cleared");
    u_ctrl.xfer(mk(1'b0, OFS_THERMAL_OC, 8'hFF), 16, rx);
    chk("write reply", rx, {e_sum(), 8'h00});
    rd(OFS_THERMAL_OC, 8'h00, "after write");
    rd(6'h03, 8'h00, "reserved");
    rd(6'h0D, 8'h00, "unmapped");
    m_ser = 1'b1;
    tick(2);
    chk("address fault", {8'h00, sum}, {8'h00, e_sum()});
    clr();
    bad(mk(1'b1, OFS_THERMAL_OC, 8'h00) ^ 16'h0100, 16);
    bad(mk(1'b1, OFS_THERMAL_OC, 8'h00), 8);
    por = 1'b1;
    tick(1);
    por = 1'b0;
    m_por = 1'b1;
    tick(3);
    chk("por seen", {8'h00, sum}, {8'h00, e_sum()});
    drive(32'h10);
    drive(32'h00);
    slp_n = 1'b0;
    tick(1);
    slp_n = 1'b1;
    {m_por, m_warn, m_shut, m_ser} = 4'b1000;
    tick(3);
    chk("sleep summary", {8'h00, sum}, {8'h00, STAT_RST});
    rd(OFS_THERMAL_OC, STAT_RST, "sleep reg1");
    report_and_stop();
  end

  // About 6300 cycles expected, limit at 18000, near three times that
  initial begin
    #1_800_000;
    n_mismatch++;
    report_and_stop();
  end
endmodule // mds_status_bank_tb_top
